/* File: pie_vector_map.sv */
// What this block does
// [R1] Reset from pin or watchdog: top, 0000h, unmaskable
// [R2] NMI priority 3, vector 0024h, software only
// [R3] Power protect: line one, bit 0.0, 0020h
// [R4] Converter done high mode: line one, bit 0.1
// [R5] External pins: line one, bits 0.2/0.3
// [R6] Serial receive high mode: line one, bit 0.5
// [R7] Serial transmit high mode: line one, bit 0.6
// [R8] Compares one to three: line two, bits 0.9-0.11
// [R9] Timer one period: line two, bit 0.12, 0027h
// [R10] Timer one compare: line two, bit 0.13
// [R11] Timer one underflow: line two, bit 0.14
// [R12] Timer one overflow: line two, bit 0.15
// [R13] Timer two period: line three, bit 1.0
// [R14] Timer two compare: line three, bit 1.1
// [R15] Timer two underflow: line three, bit 1.2
// [R16] Timer two overflow: line three, bit 1.3
// [R17] Capture one: line four, bit 1.4, 0033h
// [R18] Serial receive low mode: line five, bit 1.8
// [R19] Serial transmit low mode: line five, bit 1.9
// [R20] Unused positions never hold a request
// [R21] Requests share six core lines, vector code supplied
// [R22] Maskable requests disabled after reset until enabled
`timescale 1ns/100ps
module pie_vector_map (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	// Interrupt sources
	input wire pie_pkg::source_req_t source_req_i,
	input wire logic ext_reset_pin_i,
	input wire logic watchdog_timeout_i,
	// Core side
	input wire logic core_iack_i,
	input wire logic [2:0] core_iack_line_i,
	output logic [pie_pkg::NUM_LINES-1:0] core_line_o,
	output logic core_reset_o,
	output logic core_nmi_o,
	output logic [15:0] core_vector_addr_o,
	output logic [15:0] peripheral_vector_code_o,
	// AXI4-Lite write channels
	input wire logic awvalid_i,
	input wire logic [pie_pkg::ADDR_W-1:0] awaddr_i,
	output logic awready_o,
	input wire logic wvalid_i,
	input wire logic [31:0] wdata_i,
	input wire logic [3:0] wstrb_i,
	output logic wready_o,
	output logic bvalid_o,
	output logic [1:0] bresp_o,
	input wire logic bready_i,
	// AXI4-Lite read channels
	input wire logic arvalid_i,
	input wire logic [pie_pkg::ADDR_W-1:0] araddr_i,
	output logic arready_o,
	output logic rvalid_o,
	output logic [31:0] rdata_o,
	output logic [1:0] rresp_o,
	input wire logic rready_i
);

	pie_pkg::pie_state_t st;
	pie_pkg::pie_state_t next_st;
	logic [31:0] set;
	logic [31:0] clr;
	logic [31:0] ackset;
	logic [31:0] ackclr;
	logic [31:0] wmask;
	logic [31:0] wd;
	logic hit;
	logic [4:0] hit_pos;

	// ------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------

	// Whole block as one combinational step over the state record
	always_comb
	begin
		next_st = st;
		set = '0;
		clr = '0;
		ackset = '0;
		ackclr = '0;
		hit = 1'b0;
		hit_pos = '0;
		// Source to flag position mapping
		set[pie_pkg::POS_POWER] = source_req_i.power_protect_request; // [R3]
		set[pie_pkg::POS_CONV] = source_req_i.converter_done_request; // [R4]
		set[pie_pkg::POS_EXT_ONE] = source_req_i.ext_pin_irq_one; // [R5]
		set[pie_pkg::POS_EXT_TWO] = source_req_i.ext_pin_irq_two; // [R5]
		// Serial requests follow the priority mode bit
		set[pie_pkg::POS_RX_HIGH] = source_req_i.serial_receive_request & ~st.serial_low; // [R6]
		set[pie_pkg::POS_TX_HIGH] = source_req_i.serial_transmit_request & ~st.serial_low; // [R7]
		set[pie_pkg::POS_RX_LOW] = source_req_i.serial_receive_request & st.serial_low; // [R18]
		set[pie_pkg::POS_TX_LOW] = source_req_i.serial_transmit_request & st.serial_low; // [R19]
		set[pie_pkg::POS_CMP_ONE] = source_req_i.compare_one_request; // [R8]
		set[pie_pkg::POS_CMP_ONE + 1] = source_req_i.compare_two_request; // [R8]
		set[pie_pkg::POS_CMP_ONE + 2] = source_req_i.compare_three_request; // [R8]
		set[pie_pkg::POS_T1_PERIOD] = source_req_i.timer_one_period_request; // [R9]
		set[pie_pkg::POS_T1_PERIOD + 1] = source_req_i.timer_one_compare_request; // [R10]
		set[pie_pkg::POS_T1_PERIOD + 2] = source_req_i.timer_one_underflow_request; // [R11]
		set[pie_pkg::POS_T1_PERIOD + 3] = source_req_i.timer_one_overflow_request; // [R12]
		set[pie_pkg::POS_T2_PERIOD] = source_req_i.timer_two_period_request; // [R13]
		set[pie_pkg::POS_T2_PERIOD + 1] = source_req_i.timer_two_compare_request; // [R14]
		set[pie_pkg::POS_T2_PERIOD + 2] = source_req_i.timer_two_underflow_request; // [R15]
		set[pie_pkg::POS_T2_PERIOD + 3] = source_req_i.timer_two_overflow_request; // [R16]
		set[pie_pkg::POS_CAP_ONE] = source_req_i.capture_one_request; // [R17]
		// Only enabled, existing positions latch; enables start clear
		set = set & st.enable & pie_pkg::PRESENT_MASK; // [R20] [R22]

		// Lowest pending position on the acknowledged line wins
		for (int i = 0; i < pie_pkg::NUM_BITS; i++)
		begin
			if (!hit && st.flags[i] && pie_pkg::LINE_TABLE[i] == core_iack_line_i)
			begin
				hit = 1'b1;
				hit_pos = 5'(i);
			end
		end
		// Acknowledge hands over the code and retires the request
		if (core_iack_i)
		begin
			if (hit)
			begin
				clr[hit_pos] = 1'b1;
				ackset[hit_pos] = 1'b1;
				next_st.vector = pie_pkg::CODE_TABLE[hit_pos]; // [R21]
			end
			else
			begin
				next_st.vector = pie_pkg::PHANTOM_CODE; // Request vanished before ack
			end
		end

		// Write channels: address and data may arrive in either order
		wmask = {{8{st.w_strb[3]}}, {8{st.w_strb[2]}}, {8{st.w_strb[1]}}, {8{st.w_strb[0]}}};
		wd = st.w_data & wmask;
		next_st.nmi = 1'b0;
		if (awvalid_i && st.aw_rdy)
		begin
			next_st.aw_got = 1'b1;
			next_st.aw_addr = awaddr_i;
		end
		if (wvalid_i && st.w_rdy)
		begin
			next_st.w_got = 1'b1;
			next_st.w_data = wdata_i;
			next_st.w_strb = wstrb_i;
		end
		if (st.aw_got && st.w_got && !st.bvalid)
		begin
			next_st.aw_got = 1'b0;
			next_st.w_got = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = pie_pkg::RESP_OKAY;
			case (st.aw_addr)
				pie_pkg::OFF_REQ0: clr = clr | {{pie_pkg::GROUP_W{1'b0}}, wd[15:0]};
				pie_pkg::OFF_REQ1: clr = clr | {wd[15:0], {pie_pkg::GROUP_W{1'b0}}};
				pie_pkg::OFF_ACK0: ackclr = {{pie_pkg::GROUP_W{1'b0}}, wd[15:0]};
				pie_pkg::OFF_ACK1: ackclr = {wd[15:0], {pie_pkg::GROUP_W{1'b0}}};
				pie_pkg::OFF_ENABLE: next_st.enable = ((st.enable & ~wmask) | wd) & pie_pkg::PRESENT_MASK;
				pie_pkg::OFF_MODE:
				begin
					if (st.w_strb[0])
					begin
						next_st.serial_low = st.w_data[pie_pkg::MODE_SERIAL_LOW_BIT];
					end
				end
				pie_pkg::OFF_VECTOR: next_st.bresp = pie_pkg::RESP_OKAY; // Read-only, write dropped
				pie_pkg::OFF_NMI: next_st.nmi = wd[pie_pkg::NMI_TRIGGER_BIT]; // [R2]
				default: next_st.bresp = pie_pkg::RESP_SLVERR;
			endcase
		end
		if (st.bvalid && bready_i)
		begin
			next_st.bvalid = 1'b0;
		end

		// Read channel: no read has a side effect
		if (arvalid_i && st.ar_rdy)
		begin
			next_st.rvalid = 1'b1;
			next_st.rresp = pie_pkg::RESP_OKAY;
			case (araddr_i)
				pie_pkg::OFF_REQ0: next_st.rdata = {16'h0000, st.flags[15:0]};
				pie_pkg::OFF_REQ1: next_st.rdata = {16'h0000, st.flags[31:16]};
				pie_pkg::OFF_ACK0: next_st.rdata = {16'h0000, st.acks[15:0]};
				pie_pkg::OFF_ACK1: next_st.rdata = {16'h0000, st.acks[31:16]};
				pie_pkg::OFF_ENABLE: next_st.rdata = st.enable;
				pie_pkg::OFF_MODE: next_st.rdata = {31'h0000_0000, st.serial_low};
				pie_pkg::OFF_VECTOR: next_st.rdata = {16'h0000, st.vector};
				pie_pkg::OFF_NMI: next_st.rdata = 32'h0000_0000;
				default:
				begin
					next_st.rdata = 32'h0000_0000;
					next_st.rresp = pie_pkg::RESP_SLVERR;
				end
			endcase
		end
		if (st.rvalid && rready_i)
		begin
			next_st.rvalid = 1'b0;
		end

		// A set arriving with its clear wins, so no event is lost
		next_st.flags = (st.flags & ~clr) | set;
		next_st.acks = (st.acks & ~ackclr) | ackset;
		// Ready flops are precomputed so the ports come from registers
		next_st.aw_rdy = !next_st.aw_got && !next_st.bvalid;
		next_st.w_rdy = !next_st.w_got && !next_st.bvalid;
		next_st.ar_rdy = !next_st.rvalid;

		// Group pending flags onto the shared core lines
		next_st.core_line = '0;
		for (int i = 0; i < pie_pkg::NUM_BITS; i++)
		begin
			if (next_st.flags[i] && pie_pkg::LINE_TABLE[i] != pie_pkg::LINE_NONE)
			begin
				next_st.core_line[pie_pkg::LINE_TABLE[i] - 3'h1] = 1'b1; // [R21]
			end
		end

		// Overall priority: reset, then NMI, then lowest line
		next_st.reset_req = ext_reset_pin_i | watchdog_timeout_i; // [R1]
		next_st.vaddr = pie_pkg::IDLE_VECTOR;
		for (int l = pie_pkg::NUM_LINES - 1; l >= 0; l--)
		begin
			if (next_st.core_line[l])
			begin
				next_st.vaddr = pie_pkg::LINE_VECTOR[l + 1];
			end
		end
		if (next_st.nmi)
		begin
			next_st.vaddr = pie_pkg::NMI_VECTOR; // [R2]
		end
		if (next_st.reset_req)
		begin
			next_st.vaddr = pie_pkg::RESET_VECTOR; // [R1]
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// All enables clear at reset, so nothing maskable fires early
	always_ff @(posedge ref_clk_i or negedge rst_b_i)
	begin
		if (!rst_b_i)
		begin
			st <= '0; // [R22]
		end
		else
		begin
			st <= next_st;
		end
	end

	// Outputs straight from the state record
	assign core_line_o = st.core_line;
	assign core_reset_o = st.reset_req;
	assign core_nmi_o = st.nmi;
	assign core_vector_addr_o = st.vaddr;
	assign peripheral_vector_code_o = st.vector;
	assign awready_o = st.aw_rdy;
	assign wready_o = st.w_rdy;
	assign bvalid_o = st.bvalid;
	assign bresp_o = st.bresp;
	assign arready_o = st.ar_rdy;
	assign rvalid_o = st.rvalid;
	assign rdata_o = st.rdata;
	assign rresp_o = st.rresp;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);

	// Reset request beats everything and points at address zero
	property p_reset_top;
		(ext_reset_pin_i || watchdog_timeout_i) |=>
			core_reset_o && core_vector_addr_o == pie_pkg::RESET_VECTOR;
	endproperty
	a_reset_top: assert property (p_reset_top) else $error("reset not on top"); // [R1]

	// NMI only follows a completed software write
	property p_nmi_soft;
		core_nmi_o && !core_reset_o |->
			core_vector_addr_o == pie_pkg::NMI_VECTOR && $past(st.aw_got && st.w_got);
	endproperty
	a_nmi_soft: assert property (p_nmi_soft) else $error("nmi wrong"); // [R2]

	// Enabled power protect raises line one next cycle
	property p_power_line;
		source_req_i.power_protect_request && st.enable[pie_pkg::POS_POWER] |=>
			st.flags[pie_pkg::POS_POWER] && core_line_o[0];
	endproperty
	a_power_line: assert property (p_power_line) else $error("power protect lost"); // [R3]

	// Disabled position never latches
	property p_masked;
		!st.enable[pie_pkg::POS_POWER] && !st.flags[pie_pkg::POS_POWER] |=>
			!st.flags[pie_pkg::POS_POWER];
	endproperty
	a_masked: assert property (p_masked) else $error("masked request latched"); // [R22]

	// High-mode receive lands in group 0 on line one
	property p_rx_high;
		source_req_i.serial_receive_request && !st.serial_low
			&& st.enable[pie_pkg::POS_RX_HIGH] |=> st.flags[pie_pkg::POS_RX_HIGH] && core_line_o[0];
	endproperty
	a_rx_high: assert property (p_rx_high) else $error("rx high mode wrong"); // [R6]

	// Low-mode receive lands in group 1 on line five
	property p_rx_low;
		source_req_i.serial_receive_request && st.serial_low
			&& st.enable[pie_pkg::POS_RX_LOW] |=> st.flags[pie_pkg::POS_RX_LOW] && core_line_o[4];
	endproperty
	a_rx_low: assert property (p_rx_low) else $error("rx low mode wrong"); // [R18]

	// Acknowledging line two with timer one period on top
	property p_t1_period_ack;
		core_iack_i && core_iack_line_i == 3'h2 && st.flags[pie_pkg::POS_T1_PERIOD]
			&& st.flags[11:9] == 3'h0 && !source_req_i.timer_one_period_request |=>
			peripheral_vector_code_o == 16'h0027 && st.acks[pie_pkg::POS_T1_PERIOD]
			&& !st.flags[pie_pkg::POS_T1_PERIOD];
	endproperty
	a_t1_period_ack: assert property (p_t1_period_ack) else $error("bad ack code"); // [R9]

	// Unused positions stay empty
	property p_absent;
		(st.flags & ~pie_pkg::PRESENT_MASK) == 32'h0000_0000;
	endproperty
	a_absent: assert property (p_absent) else $error("unused position set"); // [R20]

	// Line three mirrors timer two group
	property p_line_three;
		core_line_o[2] == (st.flags[19:16] != 4'h0);
	endproperty
	a_line_three: assert property (p_line_three) else $error("line three mismatch"); // [R21]

	// Capture one reaches line four
	property p_capture;
		source_req_i.capture_one_request && st.enable[pie_pkg::POS_CAP_ONE] |=> core_line_o[3];
	endproperty
	a_capture: assert property (p_capture) else $error("capture lost"); // [R17]

	// Main scenarios
	property p_cov_ack;
		core_iack_i && hit;
	endproperty
	c_cov_ack: cover property (p_cov_ack);

	property p_cov_low;
		st.serial_low && core_line_o[4];
	endproperty
	c_cov_low: cover property (p_cov_low);

	property p_cov_nmi;
		core_nmi_o;
	endproperty
	c_cov_nmi: cover property (p_cov_nmi);

endmodule

/* File: pie_pkg.sv */
package pie_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses on the AXI4-Lite slave)
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFF_REQ0 = 8'h00;
	localparam logic [7:0] OFF_REQ1 = 8'h04;
	localparam logic [7:0] OFF_ACK0 = 8'h08;
	localparam logic [7:0] OFF_ACK1 = 8'h0C;
	localparam logic [7:0] OFF_ENABLE = 8'h10;
	localparam logic [7:0] OFF_MODE = 8'h14;
	localparam logic [7:0] OFF_VECTOR = 8'h18;
	localparam logic [7:0] OFF_NMI = 8'h1C;
	localparam int MODE_SERIAL_LOW_BIT = 0;
	localparam int NMI_TRIGGER_BIT = 0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Flag positions: group 0 is bits 15..0, group 1 is bits 31..16
	// ------------------------------------------------------------
	localparam int NUM_BITS = 32;
	localparam int GROUP_W = 16;
	localparam int POS_POWER = 0;
	localparam int POS_CONV = 1;
	localparam int POS_EXT_ONE = 2;
	localparam int POS_EXT_TWO = 3;
	localparam int POS_RX_HIGH = 5;
	localparam int POS_TX_HIGH = 6;
	localparam int POS_CMP_ONE = 9;
	localparam int POS_T1_PERIOD = 12;
	localparam int POS_T2_PERIOD = 16;
	localparam int POS_CAP_ONE = 20;
	localparam int POS_RX_LOW = 24;
	localparam int POS_TX_LOW = 25;
	localparam logic [31:0] PRESENT_MASK = 32'h031F_FE6F;
	localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

	// Core line per flag bit, 0 where the position is unused
	localparam logic [2:0] LINE_NONE = 3'h0;
	localparam logic [2:0] LINE_TABLE [NUM_BITS] = '{
		3'h1, 3'h1, 3'h1, 3'h1, 3'h0, 3'h1, 3'h1, 3'h0,
		3'h0, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h2,
		3'h3, 3'h3, 3'h3, 3'h3, 3'h4, 3'h0, 3'h0, 3'h0,
		3'h5, 3'h5, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};

	// Peripheral vector code per flag bit
	localparam logic [15:0] CODE_TABLE [NUM_BITS] = '{
		16'h0020, 16'h0004, 16'h0001, 16'h0011, 16'h0000, 16'h0006, 16'h0007, 16'h0000,
		16'h0000, 16'h0021, 16'h0022, 16'h0023, 16'h0027, 16'h0028, 16'h0029, 16'h002A,
		16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h0033, 16'h0000, 16'h0000, 16'h0000,
		16'h0006, 16'h0007, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};

	// Core vector addresses
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] NMI_VECTOR = 16'h0024;
	localparam logic [15:0] PHANTOM_CODE = 16'h0000;
	localparam logic [15:0] IDLE_VECTOR = 16'h0000;
	localparam int NUM_LINES = 6;
	localparam logic [15:0] LINE_VECTOR [NUM_LINES + 1] = '{
		16'h0000, 16'h0002, 16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C};

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic power_protect_request;
		logic converter_done_request;
		logic ext_pin_irq_one;
		logic ext_pin_irq_two;
		logic serial_receive_request;
		logic serial_transmit_request;
		logic compare_one_request;
		logic compare_two_request;
		logic compare_three_request;
		logic timer_one_period_request;
		logic timer_one_compare_request;
		logic timer_one_underflow_request;
		logic timer_one_overflow_request;
		logic timer_two_period_request;
		logic timer_two_compare_request;
		logic timer_two_underflow_request;
		logic timer_two_overflow_request;
		logic capture_one_request;
	} source_req_t;

	typedef struct packed {
		logic [31:0] flags;
		logic [31:0] acks;
		logic [31:0] enable;
		logic serial_low;
		logic [15:0] vector;
		logic aw_rdy;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_rdy;
		logic w_got;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic ar_rdy;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [NUM_LINES-1:0] core_line;
		logic reset_req;
		logic nmi;
		logic [15:0] vaddr;
	} pie_state_t;

endpackage

/* File: core_model.sv */
`timescale 1ns/100ps
// ------------------------------------------------------------
// Processor core model: fetches the vector of a pending line
// ------------------------------------------------------------
module core_model (
	// Clock
	input wire logic ref_clk_i,
	// Core side of the map
	input wire logic [5:0] core_line_i,
	output logic core_iack_o,
	output logic [2:0] core_iack_line_o
);
	// Idle line shows the inverse of the last value, so a stale value never matches
	initial
	begin
		core_iack_o = 1'b0;
		core_iack_line_o = 3'h7;
	end

	// Line 0 picks the lowest pending line; any other value is forced, even if idle
	task automatic fetch(input logic [2:0] force_line, input int slow);
		logic [2:0] pick;
		repeat (slow) @(posedge ref_clk_i);
		pick = force_line;
		for (int n = 5; n >= 0; n--)
			if (force_line == 3'h0 && core_line_i[n] === 1'b1)
				pick = 3'(n + 1);
		core_iack_o <= 1'b1;
		core_iack_line_o <= pick;
		@(posedge ref_clk_i);
		core_iack_o <= 1'b0;
		core_iack_line_o <= ~pick;
	endtask
endmodule

/* File: testbench.sv */
`timescale 1ns/100ps
module testbench;
	// ------------------------------------------------------------
	// Signals and expected map
	// ------------------------------------------------------------
	logic ref_clk, rst_b, ext_rst, wdog, iack, core_rst, nmi;
	logic [2:0] iack_line;
	pie_pkg::source_req_t src;
	logic [5:0] line;
	logic [15:0] vaddr, code, nmi_vec;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int fails, total_checks, cycles, nmi_cnt;
	// Per source in field order: flag position, core line, vector code
	localparam int pos_tab [18] = '{0, 1, 2, 3, 5, 6, 9, 10, 11, 12, 13, 14, 15, 16, 17, 18, 19, 20};
	localparam int line_tab [18] = '{1, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3, 4};
	localparam logic [15:0] code_tab [18] = '{16'h0020, 16'h0004, 16'h0001, 16'h0011, 16'h0006,
		16'h0007, 16'h0021, 16'h0022, 16'h0023, 16'h0027, 16'h0028, 16'h0029, 16'h002A,
		16'h002B, 16'h002C, 16'h002D, 16'h002E, 16'h0033};

	// Device and core model
	pie_vector_map u_dut (.ref_clk_i(ref_clk), .rst_b_i(rst_b), .source_req_i(src),
		.ext_reset_pin_i(ext_rst), .watchdog_timeout_i(wdog), .core_iack_i(iack),
		.core_iack_line_i(iack_line), .core_line_o(line), .core_reset_o(core_rst),
		.core_nmi_o(nmi), .core_vector_addr_o(vaddr), .peripheral_vector_code_o(code),
		.awvalid_i(awvalid), .awaddr_i(awaddr), .awready_o(awready), .wvalid_i(wvalid),
		.wdata_i(wdata), .wstrb_i(wstrb), .wready_o(wready), .bvalid_o(bvalid),
		.bresp_o(bresp), .bready_i(bready), .arvalid_i(arvalid), .araddr_i(araddr),
		.arready_o(arready), .rvalid_o(rvalid), .rdata_o(rdata), .rresp_o(rresp),
		.rready_i(rready));
	core_model u_core (.ref_clk_i(ref_clk), .core_line_i(line), .core_iack_o(iack),
		.core_iack_line_o(iack_line));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Address and data offered together, each released at its own handshake
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic aw_done, w_done;
		aw_done = 1'b0;
		w_done = 1'b0;
		awvalid <= 1'b1;
		awaddr <= a;
		wvalid <= 1'b1;
		wdata <= d;
		while (!(aw_done && w_done))
		begin
			@(posedge ref_clk);
			if (!aw_done && awready === 1'b1)
			begin
				aw_done = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_done && wready === 1'b1)
			begin
				w_done = 1'b1;
				wvalid <= 1'b0;
			end
		end
		bready <= 1'b1;
		do @(posedge ref_clk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 1'b0;
	endtask

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		arvalid <= 1'b1;
		araddr <= a;
		do @(posedge ref_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge ref_clk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 1'b0;
	endtask

	// One-cycle source pulse; the sticky flag is settled when this returns
	task automatic pulse(input int k);
		src <= pie_pkg::source_req_t'(18'h2_0000 >> k);
		@(posedge ref_clk);
		src <= '0;
		repeat (2) @(posedge ref_clk);
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_after_reset();
		logic [31:0] d;
		logic [1:0] r;
		axi_read(pie_pkg::OFF_ENABLE, d, r);
		check("enable after reset", d, 32'h0);
		pulse(0);
		axi_read(pie_pkg::OFF_REQ0, d, r);
		check("masked flag", d, 32'h0);
		check("masked line", line, 6'h0);
		// Only byte one of the enables is written here
		wstrb <= 4'h2;
		axi_write(pie_pkg::OFF_ENABLE, 32'hFFFF_FFFF, r);
		check("strobed write resp", r, pie_pkg::RESP_OKAY);
		axi_read(pie_pkg::OFF_ENABLE, d, r);
		check("strobed enables", d, 32'h0000_FE00);
		wstrb <= 4'hF;
		axi_write(pie_pkg::OFF_ENABLE, 32'hFFFF_FFFF, r);
		axi_read(pie_pkg::OFF_ENABLE, d, r);
		check("present enables", d, 32'h031F_FE6F);
		axi_read(8'h40, d, r);
		check("unmapped read resp", r, pie_pkg::RESP_SLVERR);
		check("unmapped read data", d, 32'h0);
		axi_write(8'h40, 32'h1, r);
		check("unmapped write resp", r, pie_pkg::RESP_SLVERR);
		$display("test after_reset done");
	endtask

	// Every source alone: flag, line, core vector, then the code fetched by the core
	task automatic t_map();
		logic [31:0] d;
		logic [1:0] r;
		for (int k = 0; k < 18; k++)
		begin
			pulse(k);
			check("line", line, 32'h1 << (line_tab[k] - 1));
			check("core vector", vaddr, 2 * line_tab[k]);
			axi_read(pos_tab[k] < 16 ? pie_pkg::OFF_REQ0 : pie_pkg::OFF_REQ1, d, r);
			check("flag", d, 32'h1 << (pos_tab[k] % 16));
			u_core.fetch(3'h0, k % 3);
			@(posedge ref_clk);
			check("code", code, code_tab[k]);
			check("line cleared", line, 32'h0);
		end
		$display("test map done");
	endtask

	task automatic t_low_mode();
		logic [31:0] d;
		logic [1:0] r;
		axi_write(pie_pkg::OFF_MODE, 32'h1, r);
		pulse(4);
		pulse(5);
		axi_read(pie_pkg::OFF_REQ1, d, r);
		check("low serial flags", d, 32'h0300);
		check("low serial line", line, 6'h10);
		check("low serial vector", vaddr, 16'h000A);
		u_core.fetch(3'h0, 0);
		@(posedge ref_clk);
		check("receive code", code, 16'h0006);
		u_core.fetch(3'h0, 2);
		@(posedge ref_clk);
		check("transmit code", code, 16'h0007);
		axi_write(pie_pkg::OFF_MODE, 32'h0, r);
		$display("test low_mode done");
	endtask

	// Three on line two, one cleared by software, then a fetch of an empty line
	task automatic t_priority();
		logic [31:0] d;
		logic [1:0] r;
		axi_write(pie_pkg::OFF_ACK0, 32'hFFFF, r);
		pulse(6);
		pulse(9);
		pulse(12);
		axi_write(pie_pkg::OFF_REQ0, 32'h1000, r);
		axi_read(pie_pkg::OFF_REQ0, d, r);
		check("flags after clear", d, 32'h8200);
		u_core.fetch(3'h0, 1);
		@(posedge ref_clk);
		check("lowest first", code, 16'h0021);
		u_core.fetch(3'h0, 0);
		@(posedge ref_clk);
		check("next pending", code, 16'h002A);
		u_core.fetch(3'h2, 0);
		@(posedge ref_clk);
		check("empty line code", code, 16'h0000);
		// The code register is read-only: a write is answered but dropped
		axi_write(pie_pkg::OFF_VECTOR, 32'h0000_1234, r);
		check("code write resp", r, pie_pkg::RESP_OKAY);
		axi_read(pie_pkg::OFF_VECTOR, d, r);
		check("code register", d, 32'h0000_0000);
		axi_read(pie_pkg::OFF_ACK0, d, r);
		check("ack flags", d, 32'h8200);
		$display("test priority done");
	endtask

	// Resets and the software NMI win over a pending line even with enables off
	task automatic t_reset_nmi();
		logic [1:0] r;
		pulse(0);
		axi_write(pie_pkg::OFF_ENABLE, 32'h0, r);
		ext_rst <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check("pin reset", core_rst, 1'b1);
		check("pin reset vector", vaddr, pie_pkg::RESET_VECTOR);
		ext_rst <= 1'b0;
		wdog <= 1'b1;
		repeat (3) @(posedge ref_clk);
		check("watchdog reset", core_rst, 1'b1);
		check("watchdog vector", vaddr, 16'h0000);
		wdog <= 1'b0;
		repeat (3) @(posedge ref_clk);
		check("reset released", core_rst, 1'b0);
		check("line vector back", vaddr, 16'h0002);
		check("nmi idle", nmi_cnt, 0);
		axi_write(pie_pkg::OFF_NMI, 32'h1, r);
		repeat (3) @(posedge ref_clk);
		check("nmi pulses", nmi_cnt, 1);
		check("nmi vector", nmi_vec, 16'h0024);
		u_core.fetch(3'h0, 0);
		@(posedge ref_clk);
		check("power code", code, 16'h0020);
		$display("test reset_nmi done");
	endtask

	// ------------------------------------------------------------
	// Clock, monitor, timeout and main sequence
	// ------------------------------------------------------------
	initial
	begin
		ref_clk = 1'b0;
		forever #2 ref_clk = ~ref_clk;
	end

	// NMI pulses are counted here since they end before the write returns
	always @(posedge ref_clk)
	begin
		cycles++;
		if (nmi === 1'b1)
		begin
			nmi_cnt++;
			nmi_vec = vaddr;
		end
		if (cycles == 20000)
		begin
			fails++;
			wrap_up();
		end
	end

	initial
	begin
		rst_b = 1'b0;
		ext_rst = 1'b0;
		wdog = 1'b0;
		src = '0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hF;
		repeat (10) @(posedge ref_clk);
		check("line in reset", line, 6'h0);
		rst_b <= 1'b1;
		@(posedge ref_clk);
		t_after_reset();
		t_map();
		t_low_mode();
		t_priority();
		t_reset_nmi();
		wrap_up();
	end
endmodule
